// ==== rtl/cst_defs.svh ====
// Register map, field positions and counts of the camera serial transmit control
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
`ifndef CST_DEFS_SVH
`define CST_DEFS_SVH

// Register indices; byte address is four times the index
`define CST_CTRL_IDX   8'h33
`define CST_AUX_IDX    8'h34
`define CST_STAT_IDX   8'h3F
`define CST_CTRL_ADDR  {`CST_CTRL_IDX, 2'b00}
`define CST_AUX_ADDR   {`CST_AUX_IDX, 2'b00}
`define CST_STAT_ADDR  {`CST_STAT_IDX, 2'b00}

`define CST_CTRL_RST   7'h00
`define CST_BIT_EN     0
`define CST_BIT_CONT   1
`define CST_ULP_LSB    2
`define CST_LANE_LSB   4
`define CST_BIT_CALEN  6
`define CST_BIT_INV    2

`define CST_ULP_NORM   2'h0
`define CST_ULP_DATA   2'h1
`define CST_ULP_ALL    2'h3

// Length of the skew calibration burst in link ticks
`define CST_CAL_TICKS  6'h20

`endif

// ==== rtl/cst_pkg.sv ====
// Types shared by the camera serial transmit control
package cst_pkg;

  typedef enum logic [2:0] {
    CST_IDLE,
    CST_CLKUP,
    CST_CAL,
    CST_PKT
  } cst_state_t;

  typedef struct packed {
    logic [6:0]  ctrl;
    logic        inv;
    logic [31:0] rdata;
    cst_state_t  st;
    logic        s1;
    logic        s2;
    logic        s3;
    logic        lvl;
    logic        cal_done;
    logic        cal_ph;
    logic [5:0]  cal_cnt;
    logic [7:0]  sh;
    logic [3:0]  rem;
    logic        last;
    logic        seen;
    logic [3:0]  dhs;
    logic [3:0]  dlp;
    logic [3:0]  dbit;
    logic        chs;
    logic        clp;
  } cst_regs_t;

endpackage

// ==== rtl/cst_top.sv ====
// Camera serial transmit output control with APB register access
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/100ps
`include "cst_defs.svh"

module cst_top
  import cst_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        NRST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [9:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        LINK_CLK,
  input  wire logic        PKT_VALID,
  input  wire logic [7:0]  PKT_DATA,
  input  wire logic        PKT_LAST,
  output logic             PKT_READY,
  output logic      [3:0]  DLANE_HS,
  output logic      [3:0]  DLANE_LP00,
  output logic      [3:0]  DLANE_BIT,
  output logic             CLANE_HS,
  output logic             CLANE_LP00
);

  cst_regs_t   r_ff;
  cst_regs_t   nxt_r;
  logic        filt;
  logic        tick;
  logic        en;
  logic        allow;
  logic [1:0]  ulp;
  logic [2:0]  nlanes;
  logic [3:0]  mask;
  logic        mapped;
  logic        wr;
  logic [3:0]  nxt_rem;

  // ---------------------------------------------------------------------------
  // Decode of control fields
  // ---------------------------------------------------------------------------
  always_comb begin
    en     = r_ff.ctrl[`CST_BIT_EN];
    ulp    = r_ff.ctrl[`CST_ULP_LSB +: 2];
    // Reserved forced-LP code 10 behaves as normal operation
    allow  = en && (ulp != `CST_ULP_DATA) && (ulp != `CST_ULP_ALL);
    case (r_ff.ctrl[`CST_LANE_LSB +: 2])
      2'h0: begin
        nlanes = 3'h4;
        mask   = 4'hF;
      end
      2'h1: begin
        nlanes = 3'h3;
        mask   = 4'h7;
      end
      2'h2: begin
        nlanes = 3'h2;
        mask   = 4'h3;
      end
      default: begin
        nlanes = 3'h1;
        mask   = 4'h1;
      end
    endcase
    filt   = (r_ff.s2 == r_ff.s3) ? r_ff.s3 : r_ff.lvl;
    tick   = filt & ~r_ff.lvl;
    mapped = (PADDR == `CST_CTRL_ADDR) || (PADDR == `CST_AUX_ADDR) ||
             (PADDR == `CST_STAT_ADDR);
    wr     = PSEL && PENABLE && PWRITE && mapped;
  end

  // Zero wait states; read data is captured in the setup cycle
  assign PREADY    = 1'b1;
  assign PSLVERR   = PSEL && PENABLE && !mapped;
  assign PRDATA    = r_ff.rdata;
  assign DLANE_HS  = r_ff.dhs;
  assign DLANE_LP00 = r_ff.dlp;
  assign DLANE_BIT = r_ff.dbit;
  assign CLANE_HS  = r_ff.chs;
  assign CLANE_LP00 = r_ff.clp;
  // A new byte is taken only when the lanes finish the current one
  assign PKT_READY = (r_ff.st == CST_PKT) && tick && allow &&
                     (r_ff.rem <= {1'b0, nlanes}) && !r_ff.last;

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    nxt_r = r_ff;
    nxt_rem = 4'h0;
    // Three-stage sampling of the link clock pin
    nxt_r.s1  = LINK_CLK;
    nxt_r.s2  = r_ff.s1;
    nxt_r.s3  = r_ff.s2;
    nxt_r.lvl = filt;

    if (PSEL && !PENABLE) begin
      if (PADDR == `CST_CTRL_ADDR) begin
        nxt_r.rdata = {25'h0, r_ff.ctrl};
      end else if (PADDR == `CST_AUX_ADDR) begin
        nxt_r.rdata = {29'h0, r_ff.inv, 2'h0};
      end else if (PADDR == `CST_STAT_ADDR) begin
        nxt_r.rdata = {24'h0, r_ff.st, r_ff.cal_done, r_ff.seen,
                       r_ff.chs, nlanes[1:0]};
      end else begin
        nxt_r.rdata = 32'h0;
      end
    end
    if (wr && PADDR == `CST_CTRL_ADDR) begin
      nxt_r.ctrl = PWDATA[6:0];
    end
    if (wr && PADDR == `CST_AUX_ADDR) begin
      nxt_r.inv = PWDATA[`CST_BIT_INV];
    end

    if (!en) begin
      // Pending calibration is re-armed and waits for the enable
      nxt_r.cal_done = 1'b0;
      nxt_r.seen     = 1'b0;
    end
    if (!r_ff.ctrl[`CST_BIT_CONT]) begin
      nxt_r.seen = 1'b0;
    end

    case (r_ff.st)
      CST_IDLE: begin
        if (allow && PKT_VALID && tick) begin
          nxt_r.st = CST_CLKUP;
        end
      end
      CST_CLKUP: begin
        if (!allow) begin
          nxt_r.st = CST_IDLE;
        end else if (tick) begin
          if (r_ff.ctrl[`CST_BIT_CALEN] && !r_ff.cal_done) begin
            nxt_r.st      = CST_CAL;
            nxt_r.cal_cnt = 6'h0;
            nxt_r.cal_ph  = r_ff.inv;
          end else begin
            nxt_r.st  = CST_PKT;
            nxt_r.rem = 4'h0;
          end
        end
      end
      CST_CAL: begin
        if (!allow) begin
          nxt_r.st = CST_IDLE;
        end else if (tick) begin
          nxt_r.cal_ph  = ~r_ff.cal_ph;
          nxt_r.cal_cnt = r_ff.cal_cnt + 6'h1;
          if (r_ff.cal_cnt == `CST_CAL_TICKS - 6'h1) begin
            nxt_r.cal_done = 1'b1;
            nxt_r.st       = CST_PKT;
            nxt_r.rem      = 4'h0;
          end
        end
      end
      CST_PKT: begin
        if (!allow) begin
          nxt_r.st   = CST_IDLE;
          nxt_r.last = 1'b0;
          nxt_r.rem  = 4'h0;
        end else if (tick) begin
          if (r_ff.rem > {1'b0, nlanes}) begin
            nxt_r.sh  = r_ff.sh >> nlanes;
            nxt_r.rem = r_ff.rem - {1'b0, nlanes};
          end else if (r_ff.last) begin
            nxt_r.st   = CST_IDLE;
            nxt_r.last = 1'b0;
            nxt_r.rem  = 4'h0;
          end else if (PKT_VALID) begin
            nxt_r.sh   = PKT_DATA;
            nxt_r.rem  = 4'h8;
            nxt_r.last = PKT_LAST;
            nxt_r.seen = r_ff.ctrl[`CST_BIT_CONT];
          end else begin
            nxt_r.rem = 4'h0;
          end
        end
      end
      default: nxt_r.st = CST_IDLE;
    endcase
    nxt_rem = nxt_r.rem;

    // Lane outputs
    nxt_r.dhs  = 4'h0;
    nxt_r.dlp  = 4'h0;
    nxt_r.dbit = 4'h0;
    nxt_r.chs  = 1'b0;
    nxt_r.clp  = 1'b0;
    if (en) begin
      if (ulp == `CST_ULP_DATA || ulp == `CST_ULP_ALL) begin
        nxt_r.dlp = mask;
      end
      if (ulp == `CST_ULP_ALL) begin
        nxt_r.clp = 1'b1;
      end
      if (nxt_r.st == CST_CAL) begin
        nxt_r.dhs  = mask;
        nxt_r.dbit = {4{nxt_r.cal_ph}} & mask;
      end else if (nxt_r.st == CST_PKT) begin
        nxt_r.dhs  = mask;
        nxt_r.dbit = (nxt_rem != 4'h0) ? (nxt_r.sh[3:0] & mask) : 4'h0;
      end
      // With the continuous clock bit set, the clock lane stays up between packets once one has gone out
      nxt_r.chs = !nxt_r.clp &&
                  (nxt_r.st != CST_IDLE || nxt_r.seen);
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      r_ff      <= '0;
      r_ff.ctrl <= `CST_CTRL_RST;
      r_ff.st   <= CST_IDLE;
    end else begin
      r_ff <= nxt_r;
    end
  end

endmodule // cst_top

// ==== testbench/camera_serial_tx_output_control_tb_top.sv ====
// Self-checking bench of the transmit control
`timescale 1ns/100ps
`include "cst_defs.svh"
module camera_serial_tx_output_control_tb_top;
  logic        SYS_CLK = 0, NRST = 0, LINK_CLK = 0, serr;
  logic        PSEL = 0, PENABLE = 0, PWRITE = 0, PREADY, PSLVERR;
  logic        PKT_VALID = 0, PKT_LAST = 0, PKT_READY, CLANE_HS, CLANE_LP00;
  logic [9:0]  PADDR = 0;
  logic [31:0] PWDATA = 0, PRDATA, rdat;
  logic [7:0]  PKT_DATA = 0, rx_byte;
  logic [3:0]  DLANE_HS, DLANE_BIT, DLANE_LP00, hs_or;
  int          fails = 0, tests_run = 0, rx_cnt, rdy_n;
  always #5 SYS_CLK = ~SYS_CLK;
  always #62.5 LINK_CLK = ~LINK_CLK;
  always @(posedge SYS_CLK) begin
    rdy_n += (PKT_READY === 1'b1);
    hs_or |= DLANE_HS;
  end
  cst_top i_cst_top (.SYS_CLK, .NRST, .PSEL, .PENABLE, .PWRITE, .PADDR,
    .PWDATA, .PRDATA, .PREADY, .PSLVERR, .LINK_CLK, .PKT_VALID, .PKT_DATA,
    .PKT_LAST, .PKT_READY, .DLANE_HS, .DLANE_LP00, .DLANE_BIT,
    .CLANE_HS, .CLANE_LP00);
  cst_rx_model i_cst_rx_model (.DLANE_HS, .DLANE_BIT, .LINK_CLK, .rx_byte,
    .rx_cnt);
  task check(input string n, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    PSEL <= 1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1;
    do @(posedge SYS_CLK); while (PREADY !== 1'b1);
    rdat = PRDATA;
    serr = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
  endtask
  task t_regs;
    apb(1'b0, `CST_CTRL_ADDR, 32'h0);
    check("ctrl reset", rdat, 32'h0);
    apb(1'b1, `CST_CTRL_ADDR, 32'hFF);
    apb(1'b0, `CST_CTRL_ADDR, 32'h0);
    check("ctrl rw", rdat, 32'h7F);
    apb(1'b1, `CST_AUX_ADDR, 32'hFF);
    apb(1'b0, `CST_AUX_ADDR, 32'h0);
    check("aux rw", rdat, 32'h4);
    apb(1'b0, 10'h000, 32'h0);
    check("unmapped", {rdat[30:0], serr}, 32'h1);
  endtask
  task t_block(input logic [31:0] c, input logic clp);
    logic [3:0] lp_exp;
    lp_exp = (c[0] && c[2]) ? 4'hF >> c[5:4] : 4'h0;
    apb(1'b1, `CST_CTRL_ADDR, c);
    rdy_n = 0;
    PKT_VALID <= 1;
    repeat (300) @(posedge SYS_CLK);
    #1;
    check("blocked ready", rdy_n, 0);
    check("data lanes", 32'(DLANE_HS), 0);
    check("data lp00", 32'(DLANE_LP00), 32'(lp_exp));
    check("clk lp00", 32'(CLANE_LP00), 32'(clp));
    @(posedge SYS_CLK);
    PKT_VALID <= 0;
  endtask
  task t_send(input logic [7:0] c, input logic [7:0] b, input logic inv);
    int n0;
    apb(1'b1, `CST_AUX_ADDR, {29'h0, inv, 2'h0});
    apb(1'b1, `CST_CTRL_ADDR, 32'h0);
    apb(1'b1, `CST_CTRL_ADDR, {24'h0, c});
    hs_or = 0;
    n0 = rx_cnt;
    PKT_DATA <= b;
    PKT_LAST <= 1;
    PKT_VALID <= 1;
    do @(posedge SYS_CLK); while (PKT_READY !== 1'b1);
    PKT_VALID <= 0;
    check("cal bits", 32'(rx_cnt - n0 >= 32), 32'(c[6]));
    // Last seven calibration bits end just before the idle first PKT tick
    if (c[6])
      check("cal pattern", 32'(rx_byte[6:0]), inv ? 32'h2A : 32'h55);
    repeat (200) @(posedge SYS_CLK);
    #1;
    check("lanes used", 32'(hs_or), 32'(4'hF >> c[5:4]));
    if (c[5:4] == 2'h3)
      check("lane0 byte", 32'(rx_byte), 32'(b));
    check("clk cont", 32'(CLANE_HS), 32'(c[1]));
  endtask
  task wrap_up;
    $display("Checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge SYS_CLK);
    NRST <= 1;
    t_regs;
    t_block(32'h30, 1'b0);
    t_block(32'h35, 1'b0);
    t_block(32'h3D, 1'b1);
    // Calibration and continuous clock stay off while every lane count is sent
    for (int i = 0; i < 4; i++)
      t_send({2'h0, 2'(i), 4'h1}, 8'hA5, 1'b0);
    t_send(8'h73, 8'h3C, 1'b1);
    t_send(8'h61, 8'h96, 1'b0);
    wrap_up;
  end
  initial begin
    #200000;
    fails++;
    wrap_up;
  end
endmodule // camera_serial_tx_output_control_tb_top

// ==== testbench/cst_rx_model.sv ====
// Far-side receiver model watching data lane zero
`timescale 1ns/100ps
module cst_rx_model (
  input wire logic [3:0] DLANE_HS,
  input wire logic [3:0] DLANE_BIT,
  input wire logic       LINK_CLK,
  output logic     [7:0] rx_byte,
  output int             rx_cnt
);
  initial rx_cnt = 0;
  // Mid-bit sampling gives the lanes time to settle after the tick
  always @(negedge LINK_CLK)
    if (DLANE_HS[0] === 1'b1) begin
      rx_byte = {DLANE_BIT[0], rx_byte[7:1]};
      rx_cnt++;
    end
endmodule // cst_rx_model

// ==== testbench/cst_top_asserts.sv ====
// Assertion checker bound to the transmit control top
`timescale 1ns/100ps
module cst_top_asserts (
  input wire logic        SYS_CLK,
  input wire logic        NRST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [9:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        PKT_READY,
  input wire logic [3:0]  DLANE_HS,
  input wire logic        CLANE_HS,
  input wire logic        CLANE_LP00
);
  // ---------------------------------------------------------------
  // Control shadow, kept from observed writes
  // ---------------------------------------------------------------
  logic [6:0] ctl_ff;
  wire  [3:0] lmask = 4'hF >> ctl_ff[5:4];
  always_ff @(posedge SYS_CLK)
    if (!NRST)
      ctl_ff <= 7'h00;
    else if (PSEL && PENABLE && PWRITE && PADDR == 10'h0CC)
      ctl_ff <= PWDATA[6:0];
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  sequence ctl_read;
    PSEL && !PENABLE && !PWRITE && PADDR == 10'h0CC;
  endsequence
  chk_ready_const: assert property (PSEL |-> PREADY)
    else $error("pready dropped");
  chk_unmapped_err: assert property (PSEL && PENABLE |-> PSLVERR ==
    !(PADDR inside {10'h0CC, 10'h0D0, 10'h0FC})) else $error("bad pslverr");
  chk_ctl_readback: assert property (
    ctl_read |=> PRDATA == {25'h0, ctl_ff}) else $error("ctrl readback");
  chk_off_no_ready: assert property (!ctl_ff[0] |-> !PKT_READY)
    else $error("ready while off");
  chk_lp_no_ready: assert property (ctl_ff[2] |-> !PKT_READY)
    else $error("ready while forced lp");
  chk_off_lanes_idle: assert property (
    !ctl_ff[0] [*2] |-> DLANE_HS == 4'h0 && !CLANE_HS)
    else $error("lanes active while off");
  chk_clk_lane_lp: assert property (
    (ctl_ff[3:0] == 4'hD) [*2] |-> CLANE_LP00 && !CLANE_HS)
    else $error("clock lane not forced");
  chk_lane_mask: assert property (
    DLANE_HS != 4'h0 |-> (DLANE_HS & ~lmask) == 4'h0)
    else $error("inactive lane in hs");
  chk_ready_pulse: assert property (PKT_READY |=> !PKT_READY)
    else $error("ready longer than one cycle");
endmodule // cst_top_asserts
bind cst_top cst_top_asserts i_chk (.SYS_CLK, .NRST, .PSEL, .PENABLE,
  .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .PKT_READY,
  .DLANE_HS, .CLANE_HS, .CLANE_LP00);
